// File: hw/startup_seq_pkg.sv
// Purpose: shared constants for the resonant start-up supply sequencer
// Assumes: 10 MHz system clock
// Notes: thresholds are analog; comparator flags plus protect, burst idle and readout-done inputs reach this logic
package startup_seq_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    // dead time between gate hand-over, in ns
    localparam int unsigned DEAD_TIME_NS = 300;
    localparam int unsigned DEAD_CYCLES_RAW = (DEAD_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned DEAD_CYCLES = (DEAD_CYCLES_RAW < 1) ? 1 : DEAD_CYCLES_RAW;
    // settings readout duration, in us
    localparam int unsigned READOUT_TIME_US = 100;
    localparam int unsigned READOUT_CYCLES = READOUT_TIME_US * (CLK_HZ / 1_000_000);
    localparam int unsigned CNT_W = 12;
    localparam int unsigned SYNC_STAGES = 2;
    localparam logic RESET_HV_SWITCH = 1'b0;
    localparam logic RESET_CURRENT_LIMIT = 1'b1;
    localparam logic RESET_BOOST_HOLD = 1'b1;

    typedef enum logic [2:0] {
        ST_NO_SUPPLY = 3'b000,
        ST_READOUT   = 3'b001,
        ST_WAIT_BOOST = 3'b011,
        ST_RUN       = 3'b010,
        ST_BURST_IDLE = 3'b110,
        ST_PROTECT   = 3'b111
    } seq_state_type;

    typedef enum logic [1:0] {
        GATE_LOW_ON  = 2'b00,
        GATE_DEAD_LH = 2'b01,
        GATE_HIGH_ON = 2'b11,
        GATE_DEAD_HL = 2'b10
    } gate_state_type;
endpackage : startup_seq_pkg

// File: hw/flag_sync.sv
// Purpose: two-stage synchroniser bank for comparator flags
// Assumes: flags are asynchronous levels
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module flag_sync #(
    parameter int unsigned WIDTH = 8
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_bit
            always_ff @(posedge sys_clk_i)
            begin
                if (!nrst_i)
                begin
                    meta[g] <= 1'b0;
                    sync_o[g] <= 1'b0;
                end
                else
                begin
                    meta[g] <= async_i[g];
                    sync_o[g] <= meta[g];
                end
            end
        end
    endgenerate
endmodule : flag_sync

// File: hw/resonant_startup_supply_sequencer.sv
// Purpose: start-up, supply sequencing and capacitor-voltage gate switching
// Assumes: all comparator flags asynchronous, active high, made by analog circuitry
// Notes: protection detection and power-mode selection arrive as plain inputs
`timescale 1ns/1ps

// What this block does
// - below the main supply reset level the start-up charge current is limited, above it the series switch closes.
// - after the main supply first reaches start level it is held there with hysteresis by the start-up switch.
// - once start-up is done and the converter switches normally the high-voltage source stays off.
// - in protection mode the main supply is regulated to its start level with the same hysteresis.
// - in burst idle the start-up switch turns on below a low threshold, regulating with hysteresis.
// - gate switching never begins before the driver supply is above its undervoltage level.
// - a driver supply undervoltage during operation stops switching and restarts the sequence.
// - either supply below its stop level enters no-supply and recharges both through the high-voltage input.
// - with both supplies at start level the settings pins are measured in a readout state.
// - the boost sense pin is held low during no-supply and readout and released afterwards.
// - half-bridge switching starts only after boost sense reaches its start level.
// - a feedback optocurrent below regulation disables main supply charging from the high-voltage input, except in no-supply, protection and burst idle.
// - capacitor voltage above the high threshold turns the high-side gate off, then low-side on after a delay.
// - power is set by the capacitor voltage thresholds, frequency is only a result of the crossings.
// - capacitor voltage below the low threshold turns the low-side gate off, then high-side on after a delay.
module resonant_startup_supply_sequencer #(
    parameter int unsigned READOUT_LEN = startup_seq_pkg::READOUT_CYCLES,
    parameter int unsigned DEAD_LEN = startup_seq_pkg::DEAD_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic ic_above_reset_i,
    input wire logic ic_above_start_i,
    input wire logic ic_below_start_hys_i,
    input wire logic ic_below_stop_i,
    input wire logic ic_below_low_i,
    input wire logic ic_above_low_hys_i,
    input wire logic reg_above_start_i,
    input wire logic reg_below_stop_i,
    input wire logic reg_above_uvp_i,
    input wire logic boost_above_start_i,
    input wire logic fb_below_reg_i,
    input wire logic cap_above_high_i,
    input wire logic cap_below_low_i,
    input wire logic protect_i,
    input wire logic burst_idle_i,
    input wire logic readout_done_i,
    output logic hv_switch_on_o,
    output logic hv_current_limit_o,
    output logic boost_hold_low_o,
    output logic readout_active_o,
    output logic highside_gate_o,
    output logic lowside_gate_o,
    output logic switching_o
);
    localparam int unsigned NFLAG = 16;

    logic [NFLAG-1:0] raw_flags;
    logic [NFLAG-1:0] flags;
    logic ic_rst_ok;
    logic ic_start;
    logic ic_hys_low;
    logic ic_stop;
    logic ic_low;
    logic ic_low_hys;
    logic reg_start;
    logic reg_stop;
    logic reg_uvp_ok;
    logic boost_ok;
    logic fb_low;
    logic cap_high;
    logic cap_low;
    logic protect;
    logic burst_idle;
    logic readout_ext_done;

    startup_seq_pkg::seq_state_type state;
    startup_seq_pkg::seq_state_type next_state;
    startup_seq_pkg::gate_state_type gate_state;
    logic [startup_seq_pkg::CNT_W-1:0] readout_cnt;
    logic [startup_seq_pkg::CNT_W-1:0] dead_cnt;
    logic start_reached;
    logic charge_req;
    logic fb_charge_block;
    logic next_hv_switch;
    logic supply_fail;

    assign raw_flags = {ic_above_reset_i, ic_above_start_i, ic_below_start_hys_i, ic_below_stop_i,
                        ic_below_low_i, ic_above_low_hys_i, reg_above_start_i, reg_below_stop_i,
                        reg_above_uvp_i, boost_above_start_i, fb_below_reg_i, cap_above_high_i,
                        cap_below_low_i, protect_i, burst_idle_i, readout_done_i};

    flag_sync #(
        .WIDTH(NFLAG)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .async_i(raw_flags),
        .sync_o(flags)
    );

    assign {ic_rst_ok, ic_start, ic_hys_low, ic_stop, ic_low, ic_low_hys, reg_start, reg_stop,
            reg_uvp_ok, boost_ok, fb_low, cap_high, cap_low, protect, burst_idle,
            readout_ext_done} = flags;

    assign supply_fail = ic_stop || reg_stop;

    // sequencing state machine
    always_comb
    begin
        next_state = state;
        case (state)
            startup_seq_pkg::ST_NO_SUPPLY:
            begin
                if (!supply_fail && start_reached && reg_start)
                    next_state = startup_seq_pkg::ST_READOUT;
            end
            startup_seq_pkg::ST_READOUT:
            begin
                if (supply_fail)
                    next_state = startup_seq_pkg::ST_NO_SUPPLY;
                else if (readout_cnt >= startup_seq_pkg::CNT_W'(READOUT_LEN) && readout_ext_done)
                    next_state = startup_seq_pkg::ST_WAIT_BOOST;
            end
            startup_seq_pkg::ST_WAIT_BOOST:
            begin
                if (supply_fail)
                    next_state = startup_seq_pkg::ST_NO_SUPPLY;
                else if (protect)
                    next_state = startup_seq_pkg::ST_PROTECT;
                else if (boost_ok && reg_uvp_ok)
                    next_state = startup_seq_pkg::ST_RUN;
            end
            startup_seq_pkg::ST_RUN, startup_seq_pkg::ST_BURST_IDLE:
            begin
                if (supply_fail || !reg_uvp_ok)
                    next_state = startup_seq_pkg::ST_NO_SUPPLY;
                else if (protect)
                    next_state = startup_seq_pkg::ST_PROTECT;
                else if (burst_idle)
                    next_state = startup_seq_pkg::ST_BURST_IDLE;
                else
                    next_state = startup_seq_pkg::ST_RUN;
            end
            startup_seq_pkg::ST_PROTECT:
            begin
                if (supply_fail)
                    next_state = startup_seq_pkg::ST_NO_SUPPLY;
                else if (!protect)
                    next_state = startup_seq_pkg::ST_NO_SUPPLY; // restart through readout
            end
            default:
                next_state = startup_seq_pkg::ST_NO_SUPPLY;
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
            state <= startup_seq_pkg::ST_NO_SUPPLY;
        else
            state <= next_state;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
            readout_cnt <= '0;
        else if (state != startup_seq_pkg::ST_READOUT)
            readout_cnt <= '0;
        else if (readout_cnt < startup_seq_pkg::CNT_W'(READOUT_LEN))
            readout_cnt <= readout_cnt + 1'b1;
    end

    // start level seen once since the last supply fail in no-supply; gates the hysteresis loop
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
            start_reached <= 1'b0;
        else if (state == startup_seq_pkg::ST_NO_SUPPLY && supply_fail)
            start_reached <= 1'b0;
        else if (ic_start)
            start_reached <= 1'b1;
    end

    // hysteretic charge request around start level, or low level in burst idle
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
            charge_req <= 1'b1;
        else if (state == startup_seq_pkg::ST_BURST_IDLE)
        begin
            if (ic_low)
                charge_req <= 1'b1;
            else if (ic_low_hys)
                charge_req <= 1'b0;
        end
        else if (!start_reached)
            charge_req <= 1'b1;
        else if (ic_hys_low)
            charge_req <= 1'b1;
        else if (ic_start)
            charge_req <= 1'b0;
    end

    // near regulation the aux winding must carry the supply
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
            fb_charge_block <= 1'b0;
        else if (state == startup_seq_pkg::ST_NO_SUPPLY)
            fb_charge_block <= 1'b0;
        else if (fb_low)
            fb_charge_block <= 1'b1;
    end

    always_comb
    begin
        case (state)
            startup_seq_pkg::ST_NO_SUPPLY, startup_seq_pkg::ST_READOUT,
            startup_seq_pkg::ST_WAIT_BOOST, startup_seq_pkg::ST_PROTECT:
                next_hv_switch = charge_req && !(fb_charge_block && state != startup_seq_pkg::ST_PROTECT);
            startup_seq_pkg::ST_BURST_IDLE:
                next_hv_switch = charge_req;
            default:
                next_hv_switch = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            hv_switch_on_o <= startup_seq_pkg::RESET_HV_SWITCH;
            hv_current_limit_o <= startup_seq_pkg::RESET_CURRENT_LIMIT;
        end
        else
        begin
            hv_switch_on_o <= next_hv_switch && ic_rst_ok;
            hv_current_limit_o <= next_hv_switch && !ic_rst_ok;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            boost_hold_low_o <= startup_seq_pkg::RESET_BOOST_HOLD;
            readout_active_o <= 1'b0;
        end
        else
        begin
            boost_hold_low_o <= (next_state == startup_seq_pkg::ST_NO_SUPPLY)
                             || (next_state == startup_seq_pkg::ST_READOUT);
            readout_active_o <= next_state == startup_seq_pkg::ST_READOUT;
        end
    end

    // cap-voltage switching: only threshold crossings move the gates, no frequency set
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            gate_state <= startup_seq_pkg::GATE_LOW_ON;
            dead_cnt <= '0;
        end
        else if (next_state != startup_seq_pkg::ST_RUN)
        begin
            gate_state <= startup_seq_pkg::GATE_LOW_ON;
            dead_cnt <= '0;
        end
        else
        begin
            case (gate_state)
                startup_seq_pkg::GATE_LOW_ON:
                begin
                    dead_cnt <= '0;
                    if (cap_low)
                        gate_state <= startup_seq_pkg::GATE_DEAD_LH;
                end
                startup_seq_pkg::GATE_DEAD_LH:
                begin
                    dead_cnt <= dead_cnt + 1'b1;
                    if (dead_cnt + 1'b1 >= startup_seq_pkg::CNT_W'(DEAD_LEN))
                        gate_state <= startup_seq_pkg::GATE_HIGH_ON;
                end
                startup_seq_pkg::GATE_HIGH_ON:
                begin
                    dead_cnt <= '0;
                    if (cap_high)
                        gate_state <= startup_seq_pkg::GATE_DEAD_HL;
                end
                startup_seq_pkg::GATE_DEAD_HL:
                begin
                    dead_cnt <= dead_cnt + 1'b1;
                    if (dead_cnt + 1'b1 >= startup_seq_pkg::CNT_W'(DEAD_LEN))
                        gate_state <= startup_seq_pkg::GATE_LOW_ON;
                end
                default:
                    gate_state <= startup_seq_pkg::GATE_LOW_ON;
            endcase
        end
    end

    // low side leads in run so the bootstrap charges; next_state keeps gates and boost hold on one edge
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            highside_gate_o <= 1'b0;
            lowside_gate_o <= 1'b0;
            switching_o <= 1'b0;
        end
        else
        begin
            highside_gate_o <= next_state == startup_seq_pkg::ST_RUN
                            && gate_state == startup_seq_pkg::GATE_HIGH_ON && reg_uvp_ok;
            lowside_gate_o <= next_state == startup_seq_pkg::ST_RUN
                           && gate_state == startup_seq_pkg::GATE_LOW_ON && reg_uvp_ok;
            switching_o <= next_state == startup_seq_pkg::ST_RUN;
        end
    end
endmodule : resonant_startup_supply_sequencer

// File: bench/seq_monitor.sv
// Purpose: port-level checks for the start-up supply sequencer
// Assumes: one clock domain, synchronous active-low reset
// Notes: latency margins follow the 2-flop flag synchroniser
`timescale 1ns/1ps
module seq_monitor #(
    parameter int unsigned READOUT_LEN = 8,
    parameter int unsigned DEAD_LEN = 3
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic ic_above_reset_i,
    input wire logic reg_above_uvp_i,
    input wire logic boost_above_start_i,
    input wire logic cap_above_high_i,
    input wire logic cap_below_low_i,
    input wire logic hv_switch_on_o,
    input wire logic hv_current_limit_o,
    input wire logic boost_hold_low_o,
    input wire logic readout_active_o,
    input wire logic highside_gate_o,
    input wire logic lowside_gate_o,
    input wire logic switching_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    property p_gate_excl;
        !(highside_gate_o && lowside_gate_o);
    endproperty
    a_gate_excl: assert property (p_gate_excl) else $error("both gates on");
    property p_gate_run;
        (highside_gate_o || lowside_gate_o) |-> switching_o;
    endproperty
    a_gate_run: assert property (p_gate_run) else $error("gate on outside run");
    property p_uvp_stop;
        !reg_above_uvp_i [*5] |=> !switching_o && !highside_gate_o && !lowside_gate_o;
    endproperty
    a_uvp_stop: assert property (p_uvp_stop) else $error("switching kept after uvp");
    property p_hold_readout;
        readout_active_o |-> boost_hold_low_o;
    endproperty
    a_hold_readout: assert property (p_hold_readout) else $error("boost released in readout");
    property p_run_released;
        switching_o |-> !boost_hold_low_o;
    endproperty
    a_run_released: assert property (p_run_released) else $error("boost held in run");
    property p_run_no_hv;
        switching_o && $past(switching_o) |-> !hv_switch_on_o;
    endproperty
    a_run_no_hv: assert property (p_run_no_hv) else $error("hv source on in run");
    property p_limit_excl;
        hv_switch_on_o |-> !hv_current_limit_o;
    endproperty
    a_limit_excl: assert property (p_limit_excl) else $error("switch closed and limited");
    property p_below_reset;
        !ic_above_reset_i [*5] |=> !hv_switch_on_o;
    endproperty
    a_below_reset: assert property (p_below_reset) else $error("switch closed below reset");
    property p_boost_first;
        $rose(switching_o) |-> $past(boost_above_start_i, 3);
    endproperty
    a_boost_first: assert property (p_boost_first) else $error("run before boost level");
    property p_dead_hl;
        $fell(highside_gate_o) |-> !lowside_gate_o [*3];
    endproperty
    a_dead_hl: assert property (p_dead_hl) else $error("no dead time high to low");
    property p_cap_low;
        lowside_gate_o && cap_below_low_i |-> ##[1:6] !lowside_gate_o;
    endproperty
    a_cap_low: assert property (p_cap_low) else $error("lowside kept below low");
    c_run: cover property ($rose(switching_o));
    c_high: cover property ($rose(highside_gate_o));
    c_readout: cover property ($rose(readout_active_o));
endmodule : seq_monitor

// File: bench/pfc_model.sv
// Purpose: companion power factor stage seen through the boost sense pin
// Assumes: boost rises a fixed number of cycles after release
// Notes: flag drops at once while the pin is held low
`timescale 1ns/1ps
module pfc_model #(
    parameter int unsigned RISE = 8
) (
    input wire logic sys_clk_i,
    input wire logic hold_low_i,
    output logic boost_o = 1'b0
);
    int unsigned ramp = 0;
    always @(posedge sys_clk_i)
    begin
        if (hold_low_i !== 1'b0)
        begin
            ramp <= 0;
            boost_o <= 1'b0;
        end
        else if (ramp < RISE)
            ramp <= ramp + 1;
        else
            boost_o <= 1'b1;
    end
endmodule : pfc_model

// File: bench/resonant_startup_supply_sequencer_tb.sv
// Purpose: self-checking bench for the start-up supply sequencer
// Assumes: inputs change on the falling edge, 6 cycles settle any flag
// Notes: one pass through start-up, gates, uvp, protection, burst idle and stop
`timescale 1ns/1ps
module resonant_startup_supply_sequencer_tb;
    localparam int unsigned READOUT_LEN = 8;
    localparam int unsigned DEAD_LEN = 3;
    logic sys_clk_i = 1'b0, nrst_i = 1'b0, ic_above_reset_i = 1'b0, ic_above_start_i = 1'b0;
    logic ic_below_start_hys_i = 1'b0, ic_below_stop_i = 1'b0, ic_below_low_i = 1'b0;
    logic ic_above_low_hys_i = 1'b0, reg_above_start_i = 1'b0, reg_below_stop_i = 1'b0;
    logic reg_above_uvp_i = 1'b0, boost_above_start_i, fb_below_reg_i = 1'b0;
    logic cap_above_high_i = 1'b0, cap_below_low_i = 1'b0, protect_i = 1'b0;
    logic burst_idle_i = 1'b0, readout_done_i = 1'b0;
    logic hv_switch_on_o, hv_current_limit_o, boost_hold_low_o, readout_active_o;
    logic highside_gate_o, lowside_gate_o, switching_o;
    int fails = 0;
    int cmp_count = 0;
    int cycles = 0;
    resonant_startup_supply_sequencer #(.READOUT_LEN(READOUT_LEN), .DEAD_LEN(DEAD_LEN)) uut (
        .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ic_above_reset_i(ic_above_reset_i),
        .ic_above_start_i(ic_above_start_i), .ic_below_start_hys_i(ic_below_start_hys_i),
        .ic_below_stop_i(ic_below_stop_i), .ic_below_low_i(ic_below_low_i),
        .ic_above_low_hys_i(ic_above_low_hys_i), .reg_above_start_i(reg_above_start_i),
        .reg_below_stop_i(reg_below_stop_i), .reg_above_uvp_i(reg_above_uvp_i),
        .boost_above_start_i(boost_above_start_i), .fb_below_reg_i(fb_below_reg_i),
        .cap_above_high_i(cap_above_high_i), .cap_below_low_i(cap_below_low_i), .protect_i(protect_i),
        .burst_idle_i(burst_idle_i), .readout_done_i(readout_done_i), .hv_switch_on_o(hv_switch_on_o),
        .hv_current_limit_o(hv_current_limit_o), .boost_hold_low_o(boost_hold_low_o),
        .readout_active_o(readout_active_o), .highside_gate_o(highside_gate_o),
        .lowside_gate_o(lowside_gate_o), .switching_o(switching_o)
    );
    pfc_model partner (.sys_clk_i(sys_clk_i), .hold_low_i(boost_hold_low_o), .boost_o(boost_above_start_i));
    always #50 sys_clk_i = ~sys_clk_i;
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up
    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == 400)
        begin
            fails++;
            wrap_up();
        end
    end
    task automatic chk(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask : step
    task automatic s_charge;
        chk(hv_current_limit_o, 1'b1);
        chk(boost_hold_low_o, 1'b1);
        chk(highside_gate_o | lowside_gate_o, 1'b0);
        ic_above_reset_i = 1'b1;
        step(6);
        chk(hv_switch_on_o, 1'b1);
        chk(hv_current_limit_o, 1'b0);
    endtask : s_charge
    task automatic s_start;
        ic_above_start_i = 1'b1;
        reg_above_start_i = 1'b1;
        reg_above_uvp_i = 1'b1;
        readout_done_i = 1'b1;
        step(6);
        chk(readout_active_o, 1'b1);
        chk(boost_hold_low_o, 1'b1);
        chk(hv_switch_on_o, 1'b0);
        for (int i = 0; i < 100 && switching_o !== 1'b1; i++)
            step(1);
        chk(switching_o, 1'b1);
        chk(boost_hold_low_o, 1'b0);
        chk(lowside_gate_o, 1'b1);
        chk(hv_switch_on_o, 1'b0);
    endtask : s_start
    task automatic s_gates;
        cap_below_low_i = 1'b1;
        step(1);
        cap_below_low_i = 1'b0;
        step(12);
        chk(highside_gate_o, 1'b1);
        chk(lowside_gate_o, 1'b0);
        cap_above_high_i = 1'b1;
        step(1);
        cap_above_high_i = 1'b0;
        step(12);
        chk(lowside_gate_o, 1'b1);
        chk(highside_gate_o, 1'b0);
    endtask : s_gates
    task automatic s_uvp;
        reg_above_uvp_i = 1'b0;
        readout_done_i = 1'b0;
        step(6);
        chk(switching_o, 1'b0);
        chk(highside_gate_o | lowside_gate_o, 1'b0);
        chk(boost_hold_low_o, 1'b1);
    endtask : s_uvp
    task automatic s_hyst;
        ic_above_start_i = 1'b0;
        ic_below_start_hys_i = 1'b1;
        step(6);
        chk(hv_switch_on_o, 1'b1);
        ic_above_start_i = 1'b1;
        ic_below_start_hys_i = 1'b0;
        step(6);
        chk(hv_switch_on_o, 1'b0);
        // optocurrent block outlives the sag, protection overrides it
        fb_below_reg_i = 1'b1;
        ic_above_start_i = 1'b0;
        ic_below_start_hys_i = 1'b1;
        step(6);
        chk(hv_switch_on_o, 1'b0);
        protect_i = 1'b1;
        readout_done_i = 1'b1;
        step(6);
        chk(hv_switch_on_o, 1'b1);
        chk(switching_o, 1'b0);
        protect_i = 1'b0;
        step(6);
    endtask : s_hyst
    task automatic s_burst;
        reg_above_uvp_i = 1'b1;
        fb_below_reg_i = 1'b0;
        ic_above_start_i = 1'b1;
        ic_below_start_hys_i = 1'b0;
        for (int i = 0; i < 100 && switching_o !== 1'b1; i++)
            step(1);
        chk(switching_o, 1'b1);
        burst_idle_i = 1'b1;
        step(6);
        chk(switching_o, 1'b0);
        chk(hv_switch_on_o, 1'b0);
        ic_below_low_i = 1'b1;
        step(6);
        chk(hv_switch_on_o, 1'b1);
        ic_below_low_i = 1'b0;
        ic_above_low_hys_i = 1'b1;
        step(6);
        chk(hv_switch_on_o, 1'b0);
        ic_below_stop_i = 1'b1;
        step(6);
        chk(hv_switch_on_o, 1'b1);
        chk(boost_hold_low_o, 1'b1);
        chk(readout_active_o, 1'b0);
        ic_above_reset_i = 1'b0;
        step(6);
        chk(hv_switch_on_o, 1'b0);
        chk(hv_current_limit_o, 1'b1);
    endtask : s_burst
    initial
    begin
        step(12);
        nrst_i = 1'b1;
        s_charge();
        s_start();
        s_gates();
        s_uvp();
        s_hyst();
        s_burst();
        wrap_up();
    end
endmodule : resonant_startup_supply_sequencer_tb
bind resonant_startup_supply_sequencer seq_monitor #(.READOUT_LEN(READOUT_LEN), .DEAD_LEN(DEAD_LEN)) mon (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ic_above_reset_i(ic_above_reset_i),
    .reg_above_uvp_i(reg_above_uvp_i), .boost_above_start_i(boost_above_start_i),
    .cap_above_high_i(cap_above_high_i), .cap_below_low_i(cap_below_low_i),
    .hv_switch_on_o(hv_switch_on_o), .hv_current_limit_o(hv_current_limit_o),
    .boost_hold_low_o(boost_hold_low_o), .readout_active_o(readout_active_o),
    .highside_gate_o(highside_gate_o), .lowside_gate_o(lowside_gate_o), .switching_o(switching_o));
